// ---- fbsr_top.sv ----
// module: four-stage shift register with load, first-stage pair and clear
`timescale 1ns/1ps
module fbsr_top (
    input  wire logic       mclk_i,               // system clock, 10 MHz
    input  wire logic       arst_n_i,             // async reset, low
    input  wire logic       ce_i,                 // clock enable
    input  wire logic       shift_clock_i,        // pin clock, rising
    input  wire logic       load_select_n_i,      // low loads, high shifts
    input  wire logic       first_set_i,          // first-stage set
    input  wire logic       first_clr_n_i,        // first-stage clear, low
    input  wire logic [3:0] load_value_i,         // parallel data
    input  wire logic       clear_n_i,            // register clear, low
    output logic      [3:0] stage_out_o,          // stage contents
    output logic            last_stage_out_inv_o  // inverse of last stage
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------

    // reset copy; asserts at once, releases two clock edges later
    logic rst_meta_ff;
    logic rst_n_ff;

    // the release is staged so no flop sees it mid-edge;
    // this pair runs regardless of ce_i so reset can always leave
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_ff <= 1'h0;
            rst_n_ff    <= 1'h0;
        end else begin
            rst_meta_ff <= 1'h1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------

    // bundle between the top and the synchroniser bank
    fbsr_pin_if pin_bus ();

    // gather every pin into one vector, positions from the package
    assign pin_bus.raw[fbsr_pkg::PIN_VAL_LSB +: fbsr_pkg::STAGES] =
        load_value_i;
    assign pin_bus.raw[fbsr_pkg::PIN_SET]     = first_set_i;
    assign pin_bus.raw[fbsr_pkg::PIN_CLR_N]   = first_clr_n_i;
    assign pin_bus.raw[fbsr_pkg::PIN_LOAD_N]  = load_select_n_i;
    assign pin_bus.raw[fbsr_pkg::PIN_SCLK]    = shift_clock_i;
    assign pin_bus.raw[fbsr_pkg::PIN_CLEAR_N] = clear_n_i;

    // all pins come from outside the mclk domain, so each gets two flops
    fbsr_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_ff),
        .ce_i    (ce_i),
        .pins    (pin_bus.sync_mp)
    );

    // ------------------------------------------------------------------
    // clean pin values
    // ------------------------------------------------------------------

    // clean pin clock and clear, read in the current cycle
    logic sclk_s;
    logic clear_n_s;

    assign sclk_s    = pin_bus.synced[fbsr_pkg::PIN_SCLK];
    assign clear_n_s = pin_bus.synced[fbsr_pkg::PIN_CLEAR_N];

    // previous sample of the clock and of the data pins
    logic                       sclk_prv_ff;
    logic [fbsr_pkg::PIN_W-1:0] data_prv_ff;

    // data is taken from the sample before the clock was seen high;
    // that mimics a setup window and keeps data that moves together
    // with the clock edge from leaking into the capture
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sclk_prv_ff <= fbsr_pkg::SCLK_PRV_RST;
            data_prv_ff <= fbsr_pkg::SYNC_RST;
        end else if (ce_i) begin
            sclk_prv_ff <= sclk_s;
            data_prv_ff <= pin_bus.synced;
        end
    end

    // fields of the held data sample
    fbsr_pkg::fbsr_stage_t load_val_s;
    logic                  set_s;
    logic                  clr_n_s;
    logic                  load_n_s;

    assign load_val_s =
        data_prv_ff[fbsr_pkg::PIN_VAL_LSB +: fbsr_pkg::STAGES];
    assign set_s    = data_prv_ff[fbsr_pkg::PIN_SET];
    assign clr_n_s  = data_prv_ff[fbsr_pkg::PIN_CLR_N];
    assign load_n_s = data_prv_ff[fbsr_pkg::PIN_LOAD_N];

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------

    // mode from the load select level
    function automatic fbsr_pkg::fbsr_mode_e mode_of(
        input logic load_n
    );
        mode_of = load_n ? fbsr_pkg::FBSR_MODE_SHIFT
                         : fbsr_pkg::FBSR_MODE_LOAD;
    endfunction

    // next value of stage zero from the first-stage pair
    function automatic logic first_next(
        input logic set,
        input logic clr_n,
        input logic cur
    );
        case ({set, clr_n})
            2'h3:    first_next = 1'h1;  // sets, clear idle
            2'h0:    first_next = 1'h0;  // cleared
            2'h2:    first_next = ~cur;  // toggles
            2'h1:    first_next = cur;   // holds
            default: first_next = cur;   // x on the pair keeps the bit
        endcase
    endfunction

    // ------------------------------------------------------------------
    // edge and mode detection
    // ------------------------------------------------------------------

    // a rising edge is a low sample followed by a high one;
    // the pin clock needs PIN_MIN_PULSE_CYC cycles high and low
    logic sclk_rise;
    assign sclk_rise = sclk_s & ~sclk_prv_ff;

    // mode chosen from the level held at the edge
    fbsr_pkg::fbsr_mode_e mode_s;
    assign mode_s = mode_of(load_n_s);

    // ------------------------------------------------------------------
    // stage register
    // ------------------------------------------------------------------

    // stage flops and the inverted copy of the last stage
    fbsr_pkg::fbsr_stage_t stage_ff;
    fbsr_pkg::fbsr_stage_t nxt_stage;
    logic                  inv_ff;
    logic                  nxt_inv;

    // candidate values for each mode
    fbsr_pkg::fbsr_stage_t shift_val;  // shifted contents
    fbsr_pkg::fbsr_stage_t load_val;   // parallel contents

    // shift: stage n takes stage n-1, stage zero from the pair
    assign shift_val = {stage_ff[fbsr_pkg::LAST_STAGE-1:0],
                        first_next(set_s, clr_n_s,
                                   stage_ff[fbsr_pkg::FIRST_STAGE])};

    // load: the pair plays no part here
    assign load_val = load_val_s;

    // next stage value: clear overrides, then edges, else hold
    always_comb begin
        nxt_stage = stage_ff;
        if (!clear_n_s) begin
            // level clear, needs no pin clock edge
            nxt_stage = fbsr_pkg::STAGE_RST;
        end else if (sclk_rise) begin
            case (mode_s)
                fbsr_pkg::FBSR_MODE_SHIFT: begin
                    nxt_stage = shift_val;
                end
                fbsr_pkg::FBSR_MODE_LOAD: begin
                    nxt_stage = load_val;
                end
                default: begin
                    nxt_stage = stage_ff;
                end
            endcase
        end
        // no edge: inputs may move freely
    end

    // inverse computed from the next value so both flops agree
    assign nxt_inv = ~nxt_stage[fbsr_pkg::LAST_STAGE];

    // stage and inverse flops update together, frozen when ce_i is low
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            stage_ff <= fbsr_pkg::STAGE_RST;
            inv_ff   <= fbsr_pkg::INV_RST;
        end else if (ce_i) begin
            stage_ff <= nxt_stage;
            inv_ff   <= nxt_inv;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    // outputs straight from the flops; a clear shows two to three mclk
    // cycles late because the clear pin is synchronised first, a cost
    // taken to keep the pin out of the reset tree
    assign stage_out_o          = stage_ff;
    assign last_stage_out_inv_o = inv_ff;

endmodule // fbsr_top

// ---- fbsr_pkg.sv ----
// package: constants and types for the four-stage shift register block
package fbsr_pkg;

    // number of stages and the positions of the end stages
    localparam int unsigned STAGES      = 4;
    localparam int unsigned FIRST_STAGE = 0;
    localparam int unsigned LAST_STAGE  = 3;

    // depth of every pin synchroniser
    localparam int unsigned SYNC_DEPTH = 2;

    // positions of the pins inside the sampled pin bundle
    localparam int unsigned PIN_W        = 9;
    localparam int unsigned PIN_VAL_LSB  = 0;  // load_value occupies 3:0
    localparam int unsigned PIN_SET      = 4;  // first-stage set input
    localparam int unsigned PIN_CLR_N    = 5;  // first-stage clear, low
    localparam int unsigned PIN_LOAD_N   = 6;  // load_select_n
    localparam int unsigned PIN_SCLK     = 7;  // shift_clock
    localparam int unsigned PIN_CLEAR_N  = 8;  // clear_n, whole register

    // values after reset
    localparam logic [STAGES-1:0] STAGE_RST    = 4'h0;
    localparam logic              INV_RST      = 1'h1;
    localparam logic [PIN_W-1:0]  SYNC_RST     = 9'h000;
    localparam logic              SCLK_PRV_RST = 1'h0;

    // system clock and the least high or low time of a pin clock
    localparam int unsigned MCLK_PERIOD_NS   = 100;
    localparam int unsigned PIN_MIN_PULSE_NS = 200;
    localparam int unsigned PIN_MIN_PULSE_CYC =
        (PIN_MIN_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // the two operating modes
    typedef enum logic {
        FBSR_MODE_LOAD  = 1'b0,
        FBSR_MODE_SHIFT = 1'b1
    } fbsr_mode_e;

    // width of the stage vector
    typedef logic [STAGES-1:0] fbsr_stage_t;

endpackage : fbsr_pkg

// ---- fbsr_pin_if.sv ----
// interface: raw and synchronised pin bundle between top and synchroniser
`timescale 1ns/1ps
interface fbsr_pin_if;

    logic [fbsr_pkg::PIN_W-1:0] raw;     // pins as they arrive
    logic [fbsr_pkg::PIN_W-1:0] synced;  // pins after two flip-flops

    // synchroniser end: reads pins, drives clean copies
    modport sync_mp (
        input  raw,
        output synced
    );

    // core end: drives pins in, reads clean copies
    modport core_mp (
        output raw,
        input  synced
    );

endinterface : fbsr_pin_if

// ---- fbsr_sync.sv ----
// module: two-stage synchroniser bank for every pin of the register
`timescale 1ns/1ps
module fbsr_sync (
    input  wire logic   mclk_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    fbsr_pin_if.sync_mp pins
);

    // first and second flip-flop of each pin
    logic [fbsr_pkg::PIN_W-1:0] meta_ff;
    logic [fbsr_pkg::PIN_W-1:0] sync_ff;

    // one chain per pin; the first flop feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < fbsr_pkg::PIN_W; gi++) begin : g_chain
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_ff[gi] <= fbsr_pkg::SYNC_RST[gi];
                    sync_ff[gi] <= fbsr_pkg::SYNC_RST[gi];
                end else if (ce_i) begin
                    meta_ff[gi] <= pins.raw[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    // clean copies go to the core
    assign pins.synced = sync_ff;

endmodule // fbsr_sync

// ---- fbsr_top_asserts.sv ----
// checker: timing and function properties of the shift register ports
`timescale 1ns/1ps
module fbsr_top_asserts (
    input wire logic       mclk_i,
    input wire logic       arst_n_i,
    input wire logic       ce_i,
    input wire logic       shift_clock_i,
    input wire logic       load_select_n_i,
    input wire logic       first_set_i,
    input wire logic       first_clr_n_i,
    input wire logic [3:0] load_value_i,
    input wire logic       clear_n_i,
    input wire logic [3:0] stage_out_o,
    input wire logic       last_stage_out_inv_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // pin clock rise in mode m, clear idle until the update lands
    sequence s_edge(m);
        $rose(shift_clock_i) && $past(load_select_n_i) == m && ce_i
        && clear_n_i ##1 (clear_n_i && ce_i)[*2];
    endsequence
    // first-stage pair as sampled just before the rise
    sequence s_pair(j, k);
        $past(first_set_i) == j && $past(first_clr_n_i) == k;
    endsequence
    chk_load_copy: assert property (s_edge(1'b0) |=>
        stage_out_o == $past(load_value_i, 4)) else $error("load wrong");
    chk_shift_move: assert property (s_edge(1'b1) |=>
        stage_out_o[3:1] == $past(stage_out_o[2:0], 3))
        else $error("shift wrong");
    chk_first_set: assert property (
        s_pair(1'b1, 1'b1) ##0 s_edge(1'b1) |=> stage_out_o[0])
        else $error("set pair wrong");
    chk_first_reset: assert property (
        s_pair(1'b0, 1'b0) ##0 s_edge(1'b1) |=> !stage_out_o[0])
        else $error("reset pair wrong");
    chk_first_toggle: assert property (
        s_pair(1'b1, 1'b0) ##0 s_edge(1'b1) |=>
        stage_out_o[0] != $past(stage_out_o[0], 3))
        else $error("toggle pair wrong");
    chk_first_hold: assert property (
        s_pair(1'b0, 1'b1) ##0 s_edge(1'b1) |=>
        stage_out_o[0] == $past(stage_out_o[0], 3))
        else $error("hold pair wrong");
    chk_inv_mirror: assert property (
        last_stage_out_inv_o == !stage_out_o[3]) else $error("inverse bad");
    chk_clear_force: assert property ((!clear_n_i && ce_i)[*4] |->
        stage_out_o == 4'h0 && last_stage_out_inv_o)
        else $error("clear not forced");
    chk_idle_stable: assert property (
        (!shift_clock_i && clear_n_i)[*4] |=> $stable(stage_out_o))
        else $error("change without edge");
    // main scenarios: load, shift and a held clear
    cover property (s_edge(1'b0));
    cover property (s_edge(1'b1));
    cover property (!clear_n_i [*4]);
endmodule // fbsr_top_asserts

bind fbsr_top fbsr_top_asserts i_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .shift_clock_i(shift_clock_i),
    .load_select_n_i(load_select_n_i), .first_set_i(first_set_i),
    .first_clr_n_i(first_clr_n_i), .load_value_i(load_value_i),
    .clear_n_i(clear_n_i), .stage_out_o(stage_out_o),
    .last_stage_out_inv_o(last_stage_out_inv_o));

// ---- fbsr_board.sv ----
// model: board logic that pulses the pin clock and feeds shift-left data
`timescale 1ns/1ps
module fbsr_board (
    input  wire logic       mclk_i,        // system clock
    input  wire logic       go_i,          // start one pin clock frame
    input  wire logic       loop_i,        // route outputs one place down
    input  wire logic [3:0] value_i,       // parallel data otherwise
    input  wire logic [3:0] stage_i,       // register outputs fed back
    output logic            shift_clock_o, // pin clock, idle low
    output logic      [3:0] load_value_o,  // parallel data to register
    output logic            busy_o         // frame in progress
);
    logic [3:0] phase_ff = 4'h0;  // frame phase, zero when idle
    // three setup cycles, four high, eight low: wide margins keep the
    // synchronised pin well above its minimum pulse width
    // plain always: the phase starts from its declared value, no reset pin
    always @(posedge mclk_i) begin
        if (phase_ff != 4'h0) begin
            phase_ff <= phase_ff + 4'h1;
        end else if (go_i) begin
            phase_ff <= 4'h1;
        end
    end
    assign shift_clock_o = phase_ff[2] & ~phase_ff[3];  // phases 4 to 7
    assign busy_o        = phase_ff != 4'h0;
    // stage n+1 feeds load input n, top input gets zero
    assign load_value_o = loop_i ? {1'b0, stage_i[3:1]} : value_i;
endmodule // fbsr_board

// ---- tb_top.sv ----
// testbench: table-driven and hand-written checks of the shift register
`timescale 1ns/1ps
module tb_top;
    // one row: controls for a pulse and the stages it should give
    typedef struct packed {
        logic       load_n;
        logic       set;
        logic       clr_n;
        logic [3:0] value;
        logic [3:0] exp;
    } fbsr_row_s;
    logic       mclk    = 1'b0;  // system clock
    logic       arst_n  = 1'b0;  // reset, held at start
    logic       load_n  = 1'b1;  // mode select
    logic       set     = 1'b0;  // first-stage pair
    logic       clr_n   = 1'b0;
    logic [3:0] value   = 4'h0;  // parallel data
    logic       clear_n = 1'b1;  // register clear
    logic       ce      = 1'b1;  // clock enable
    logic       go      = 1'b0;  // frame request to the board
    logic       loop    = 1'b0;  // shift-left wiring on
    logic       sclk;
    logic       busy;
    logic       inv;
    logic [3:0] ld_val;
    logic [3:0] stage;
    int n_mismatch      = 0;
    int samples_checked = 0;
    int cycles          = 0;
    // each row starts from the state the previous one left
    fbsr_row_s rows [8] = '{
        '{1'b0, 1'b1, 1'b1, 4'ha, 4'ha},  // load, pair ignored
        '{1'b1, 1'b1, 1'b1, 4'h0, 4'h5},  // tied pair, one in
        '{1'b1, 1'b0, 1'b0, 4'hf, 4'ha},  // tied pair, zero in
        '{1'b1, 1'b1, 1'b0, 4'h0, 4'h5},  // toggle low to high
        '{1'b1, 1'b0, 1'b1, 4'h0, 4'hb},  // hold high
        '{1'b1, 1'b1, 1'b0, 4'h0, 4'h6},  // toggle high to low
        '{1'b0, 1'b1, 1'b0, 4'h9, 4'h9},  // load, toggle pair ignored
        '{1'b1, 1'b0, 1'b0, 4'h0, 4'h2}}; // zero in again

    fbsr_top i_fbsr_top (.mclk_i(mclk), .arst_n_i(arst_n), .ce_i(ce),
        .shift_clock_i(sclk), .load_select_n_i(load_n),
        .first_set_i(set), .first_clr_n_i(clr_n), .load_value_i(ld_val),
        .clear_n_i(clear_n), .stage_out_o(stage),
        .last_stage_out_inv_o(inv));
    fbsr_board i_fbsr_board (.mclk_i(mclk), .go_i(go), .loop_i(loop),
        .value_i(value), .stage_i(stage), .shift_clock_o(sclk),
        .load_value_o(ld_val), .busy_o(busy));

    // clock generator, 100 ns period
    initial begin
        forever #50 mclk = ~mclk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // compare one value and count it
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // stage vector and its inverted top bit together
    task automatic check_out(input logic [3:0] exp);
        check(stage, exp);
        check({3'h0, inv}, {3'h0, ~exp[3]});
    endtask
    // one board frame; returns once the board is idle again
    task automatic pulse();
        @(posedge mclk) #10 go = 1'b1;
        @(posedge mclk) #10 go = 1'b0;
        for (int i = 0; i < 40 && busy === 1'b1; i++) begin
            @(posedge mclk) #10;
        end
        // a frame that never ends counts as a mismatch
        if (busy !== 1'b0) begin
            n_mismatch++;
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence: table rows, then the awkward cases
    initial begin
        repeat (8) @(posedge mclk);
        #10 arst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #10 check_out(4'h0);
        for (int r = 0; r < 8; r++) begin
            load_n = rows[r].load_n;
            set    = rows[r].set;
            clr_n  = rows[r].clr_n;
            value  = rows[r].value;
            pulse();
            check_out(rows[r].exp);
        end
        // shift toward stage zero through the board wiring
        loop   = 1'b1;
        load_n = 1'b0;
        pulse();
        check_out(4'h1);
        loop = 1'b0;
        // busy inputs between pin clock edges must do nothing
        repeat (6) begin
            @(posedge mclk) #10 value = ~value;
            load_n = ~load_n;
            set    = ~set;
        end
        repeat (4) @(posedge mclk);
        #10 check_out(4'h1);
        // clear held low across a load edge wins
        clear_n = 1'b0;
        load_n  = 1'b0;
        value   = 4'hf;
        pulse();
        check_out(4'h0);
        clear_n = 1'b1;
        repeat (6) @(posedge mclk);
        #10 check_out(4'h0);
        pulse();
        check_out(4'hf);
        // clock enable low: a whole frame must leave the stages alone
        ce    = 1'b0;
        value = 4'h3;
        pulse();
        check_out(4'hf);
        ce = 1'b1;
        // reset in mid-run acts without a clock edge
        arst_n = 1'b0;
        #1 check_out(4'h0);
        repeat (3) @(posedge mclk);
        #10 arst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #10 pulse();
        check_out(4'h3);
        end_sim();
    end
endmodule // tb_top
